// ==== common/memory_port_pkg.sv ====
// Shared constants, register map and carrier types of the external memory port
package memory_port_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PAGE = 8'haa;
    localparam logic [7:0] IDX_CONFIG = 8'hc7;
    localparam logic [7:0] IDX_TIMING = 8'hf7;
    localparam logic [7:0] IDX_STATUS = 8'hf8;

    // Reset values
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h03;
    localparam logic [7:0] TIMING_RST = 8'hff;

    // Interface configuration fields
    localparam int CFG_MUX_BIT = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_ALE_LSB = 0;
    localparam logic [7:0] CFG_USED_MASK = 8'h1f;

    // Timing control fields
    localparam int TC_SETUP_LSB = 6;
    localparam int TC_WIDTH_LSB = 2;
    localparam int TC_HOLD_LSB = 0;

    // Status bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_OFFCHIP_BIT = 1;

    // Memory modes
    localparam logic [1:0] MODE_ONCHIP = 2'h0;
    localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
    localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
    localparam logic [1:0] MODE_OFFCHIP = 2'h3;

    // Timing counts in clock cycles and on-chip RAM size in bytes
    localparam logic [7:0] EXTRA_CYCLES = 8'h04;
    localparam logic [3:0] TAIL_LEN = 4'h1;
    localparam logic [3:0] ONCHIP_LEN = 4'h2;
    localparam int unsigned ONCHIP_SIZE = 1024;

    // Access sequencer states
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_LAUNCH = 10'h002,
        ST_ALE_H = 10'h004,
        ST_ALE_L = 10'h008,
        ST_SETUP = 10'h010,
        ST_STROBE = 10'h020,
        ST_HOLD = 10'h040,
        ST_TAIL = 10'h080,
        ST_DONE = 10'h100,
        ST_ONCHIP = 10'h200
    } state_type;

    // External-move request from the CPU
    typedef struct packed {
        logic write;
        logic wide;
        logic [7:0] index;
        logic [15:0] data_pointer;
        logic [7:0] wdata;
    } xreq_type;

    // Port pin drive bundle
    typedef struct packed {
        logic [7:0] hi;
        logic hi_oe;
        logic [7:0] lo;
        logic lo_oe;
        logic [7:0] data;
        logic data_oe;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic ctrl_oe;
    } pins_type;

endpackage

// ==== core/phase_counter.sv ====
// Down counter that times one phase of an access
`timescale 1ns/1ps
`default_nettype none
module phase_counter #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Status
    output logic last
);
    logic [W-1:0] cnt_q; // Remaining cycles minus one

    // Load on phase entry, count down to zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign last = (cnt_q == '0);
endmodule
`default_nettype wire

// ==== core/memory_route.sv ====
// Effective address forming and on-chip or off-chip routing
`timescale 1ns/1ps
`default_nettype none
module memory_route #(
    parameter int unsigned RAM_SIZE = memory_port_pkg::ONCHIP_SIZE
) (
    // Configuration
    input wire logic [1:0] mode,
    input wire logic [7:0] page,
    // Request
    input wire logic wide,
    input wire logic [7:0] index,
    input wire logic [15:0] data_pointer,
    // Result
    output logic [15:0] eff_addr,
    output logic offchip,
    output logic drive_hi
);
    localparam logic [16:0] RAM_LIMIT = 17'(RAM_SIZE);

    // Wide form uses the pointer, short form page and index
    assign eff_addr = wide ? data_pointer : {page, index};

    // Destination by memory mode
    always_comb begin
        case (mode)
            memory_port_pkg::MODE_ONCHIP: offchip = 1'b0;
            memory_port_pkg::MODE_SPLIT_NOBANK,
            memory_port_pkg::MODE_SPLIT_BANK: offchip = ({1'b0, eff_addr} >= RAM_LIMIT);
            memory_port_pkg::MODE_OFFCHIP: offchip = 1'b1;
            default: offchip = 1'b0;
        endcase
    end

    // Upper pins only for wide form or bank select
    assign drive_hi = wide | (mode == memory_port_pkg::MODE_SPLIT_BANK);
endmodule
`default_nettype wire

// ==== core/external_memory_interface.sv ====
// External data memory interface: register slave, router and bus cycle sequencer
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Config bit four picks multiplexed or separate pins
// - Multiplexed mode shares low address, data; drives latch
// - Latch high shows address, then data with strobe
// - Separate mode uses own pins, no latch phase
// - Mode 00 keeps everything on-chip, aliasing modulo 1k
// - Short form page plus index; wide form pointer
// - Mode 01 splits at on-chip size boundary
// - Mode 01 short form leaves upper pins undriven
// - Mode 01 wide form drives sixteen pins
// - Mode 10 short form drives page and index
// - Mode 11 sends every access off-chip
// - Mode 11 short form ignores page, upper undriven
// - Access lasts setup plus width plus hold plus four
// - Minimum five cycles, multiplexed two more
// - Timing register resets to all ones
// - Setup field adds zero to three cycles
// - Width field gives strobe value plus one cycles
// - Hold field keeps address zero to three cycles
// - Latch field sets high and low time
// - Pins claimed only during an off-chip access
// - Input pins undriven, data pins during reads except in the multiplexed address phase
module external_memory_interface #(
    parameter int unsigned RAM_SIZE = memory_port_pkg::ONCHIP_SIZE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM register slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU external-move request
    input wire logic xreq_valid,
    input wire memory_port_pkg::xreq_type xreq,
    output logic xreq_ready,
    output logic xdone,
    output logic [7:0] xrdata,
    // On-chip data RAM
    output logic ram_en,
    output logic ram_we,
    output logic [9:0] ram_addr,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata,
    // Port pins
    output memory_port_pkg::pins_type pins,
    input wire logic [7:0] data_i
);
    // Registers
    logic [7:0] page_q; // Page register
    logic [7:0] config_q; // Interface configuration
    logic [7:0] timing_q; // Timing control
    logic ack_q; // Bus answer cycle
    logic [31:0] readdata_q; // Bus read data
    // Access snapshot
    memory_port_pkg::xreq_type req_q;
    logic [7:0] cfg_snap_q;
    logic [7:0] tc_snap_q;
    logic [15:0] eff_q;
    logic drive_hi_q;
    logic offchip_q;
    // Sequencer
    memory_port_pkg::state_type state_q, state_d;
    memory_port_pkg::pins_type pins_q, pins_d;
    logic cap_q; // Last strobe cycle on the pins
    logic oc_cap_q; // On-chip read data valid
    logic [7:0] xrdata_q;
    logic ram_en_q;
    logic phase_last;
    logic [15:0] route_addr;
    logic route_offchip;
    logic route_hi;

    // Snapshot fields
    wire logic mux_mode = ~cfg_snap_q[memory_port_pkg::CFG_MUX_BIT];
    wire logic [1:0] ale_f = cfg_snap_q[memory_port_pkg::CFG_ALE_LSB +: 2];
    wire logic [1:0] setup_f = tc_snap_q[memory_port_pkg::TC_SETUP_LSB +: 2];
    wire logic [3:0] width_f = tc_snap_q[memory_port_pkg::TC_WIDTH_LSB +: 4];
    wire logic [1:0] hold_f = tc_snap_q[memory_port_pkg::TC_HOLD_LSB +: 2];
    wire logic bus_req = avs_read | avs_write;
    wire logic [7:0] bus_idx = avs_address[9:2];

    // Router on the incoming request and live configuration
    memory_route #(.RAM_SIZE(RAM_SIZE)) u_route (
        .mode(config_q[memory_port_pkg::CFG_MODE_LSB +: 2]),
        .page(page_q),
        .wide(xreq.wide),
        .index(xreq.index),
        .data_pointer(xreq.data_pointer),
        .eff_addr(route_addr),
        .offchip(route_offchip),
        .drive_hi(route_hi)
    );

    // Bus answer one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end
    assign avs_waitrequest = bus_req & ~ack_q;

    // Register writes take effect on the answer edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            page_q <= memory_port_pkg::PAGE_RST;
            config_q <= memory_port_pkg::CONFIG_RST;
            timing_q <= memory_port_pkg::TIMING_RST;
        end else if (avs_write && ack_q && avs_byteenable[0]) begin
            case (bus_idx)
                memory_port_pkg::IDX_PAGE: page_q <= avs_writedata[7:0];
                memory_port_pkg::IDX_CONFIG: begin
                    config_q <= avs_writedata[7:0] & memory_port_pkg::CFG_USED_MASK;
                end
                memory_port_pkg::IDX_TIMING: timing_q <= avs_writedata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Read data prepared in the waiting cycle; unmapped reads zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readdata_q <= '0;
        end else if (avs_read && !ack_q) begin
            case (bus_idx)
                memory_port_pkg::IDX_PAGE: readdata_q <= {24'h0, page_q};
                memory_port_pkg::IDX_CONFIG: readdata_q <= {24'h0, config_q};
                memory_port_pkg::IDX_TIMING: readdata_q <= {24'h0, timing_q};
                memory_port_pkg::IDX_STATUS: begin
                    readdata_q <= {30'h0, offchip_q, state_q != memory_port_pkg::ST_IDLE};
                end
                default: readdata_q <= '0;
            endcase
        end
    end
    assign avs_readdata = readdata_q;

    // Capture request, route and timing at acceptance
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_q <= '0;
            cfg_snap_q <= memory_port_pkg::CONFIG_RST;
            tc_snap_q <= memory_port_pkg::TIMING_RST;
            eff_q <= '0;
            drive_hi_q <= 1'b0;
            offchip_q <= 1'b0;
        end else if (state_q == memory_port_pkg::ST_IDLE && xreq_valid) begin
            req_q <= xreq;
            cfg_snap_q <= config_q;
            tc_snap_q <= timing_q;
            eff_q <= route_addr;
            drive_hi_q <= route_hi;
            offchip_q <= route_offchip;
        end
    end

    // Phase length minus one for a state
    function automatic logic [3:0] phase_len(memory_port_pkg::state_type s);
        case (s)
            memory_port_pkg::ST_ALE_H,
            memory_port_pkg::ST_ALE_L: phase_len = {2'h0, ale_f};
            memory_port_pkg::ST_SETUP: phase_len = {2'h0, setup_f} - 4'h1;
            memory_port_pkg::ST_STROBE: phase_len = width_f;
            memory_port_pkg::ST_HOLD: phase_len = {2'h0, hold_f} - 4'h1;
            memory_port_pkg::ST_TAIL: phase_len = memory_port_pkg::TAIL_LEN;
            memory_port_pkg::ST_ONCHIP: phase_len = memory_port_pkg::ONCHIP_LEN;
            default: phase_len = 4'h0;
        endcase
    endfunction

    // Phase timer loaded on every state change
    phase_counter #(.W(4)) u_phase (
        .clk(clk),
        .rstn(rstn),
        .load(state_d != state_q),
        .load_val(phase_len(state_d)),
        .last(phase_last)
    );

    // Next state of the access sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            memory_port_pkg::ST_IDLE: begin
                if (xreq_valid) begin
                    state_d = route_offchip ? memory_port_pkg::ST_LAUNCH
                                            : memory_port_pkg::ST_ONCHIP;
                end
            end
            memory_port_pkg::ST_LAUNCH: begin
                if (mux_mode) begin
                    state_d = memory_port_pkg::ST_ALE_H;
                end else if (setup_f != 2'h0) begin
                    state_d = memory_port_pkg::ST_SETUP;
                end else begin
                    state_d = memory_port_pkg::ST_STROBE;
                end
            end
            memory_port_pkg::ST_ALE_H: begin
                if (phase_last) begin
                    state_d = memory_port_pkg::ST_ALE_L;
                end
            end
            memory_port_pkg::ST_ALE_L: begin
                if (phase_last) begin
                    state_d = (setup_f != 2'h0) ? memory_port_pkg::ST_SETUP
                                                : memory_port_pkg::ST_STROBE;
                end
            end
            memory_port_pkg::ST_SETUP: begin
                if (phase_last) begin
                    state_d = memory_port_pkg::ST_STROBE;
                end
            end
            memory_port_pkg::ST_STROBE: begin
                if (phase_last) begin
                    state_d = (hold_f != 2'h0) ? memory_port_pkg::ST_HOLD
                                               : memory_port_pkg::ST_TAIL;
                end
            end
            memory_port_pkg::ST_HOLD: begin
                if (phase_last) begin
                    state_d = memory_port_pkg::ST_TAIL;
                end
            end
            memory_port_pkg::ST_TAIL: begin
                if (phase_last) begin
                    state_d = memory_port_pkg::ST_DONE;
                end
            end
            memory_port_pkg::ST_ONCHIP: begin
                if (phase_last) begin
                    state_d = memory_port_pkg::ST_DONE;
                end
            end
            memory_port_pkg::ST_DONE: state_d = memory_port_pkg::ST_IDLE;
            default: state_d = memory_port_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= memory_port_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Pin drive for the current state, registered one cycle later
    always_comb begin
        logic active;
        logic in_addr;
        logic in_wdata;
        active = 1'b0;
        in_addr = 1'b0;
        in_wdata = 1'b0;
        pins_d = '0;
        pins_d.rd_n = 1'b1;
        pins_d.wr_n = 1'b1;
        case (state_q)
            memory_port_pkg::ST_LAUNCH: begin
                active = 1'b1;
                in_addr = mux_mode;
                in_wdata = ~mux_mode;
            end
            memory_port_pkg::ST_ALE_H,
            memory_port_pkg::ST_ALE_L: begin
                active = 1'b1;
                in_addr = 1'b1;
            end
            memory_port_pkg::ST_SETUP,
            memory_port_pkg::ST_STROBE,
            memory_port_pkg::ST_HOLD: begin
                active = 1'b1;
                in_wdata = 1'b1;
            end
            memory_port_pkg::ST_TAIL: active = 1'b1;
            default: active = 1'b0;
        endcase
        if (active) begin
            pins_d.ctrl_oe = 1'b1;
            pins_d.hi = eff_q[15:8];
            pins_d.hi_oe = drive_hi_q;
            pins_d.lo = eff_q[7:0];
            pins_d.lo_oe = ~mux_mode;
            pins_d.ale = (state_q == memory_port_pkg::ST_ALE_H);
            if (in_addr) begin
                pins_d.data = eff_q[7:0];
                pins_d.data_oe = 1'b1;
            end else if (in_wdata && req_q.write) begin
                pins_d.data = req_q.wdata;
                pins_d.data_oe = 1'b1;
            end
            if (state_q == memory_port_pkg::ST_STROBE) begin
                pins_d.rd_n = req_q.write;
                pins_d.wr_n = ~req_q.write;
            end
        end
    end

    // Registered pins; reads drive data pins only in the multiplexed address phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins_q <= '0;
            pins_q.rd_n <= 1'b1;
            pins_q.wr_n <= 1'b1;
        end else begin
            pins_q <= pins_d;
        end
    end
    assign pins = pins_q;

    // Read capture at the last low cycle of the read strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_q <= 1'b0;
            oc_cap_q <= 1'b0;
            ram_en_q <= 1'b0;
            xrdata_q <= '0;
        end else begin
            cap_q <= (state_q == memory_port_pkg::ST_STROBE) && phase_last && !req_q.write;
            oc_cap_q <= (state_q == memory_port_pkg::ST_ONCHIP) && phase_last;
            ram_en_q <= (state_d == memory_port_pkg::ST_ONCHIP);
            if (cap_q) begin
                xrdata_q <= data_i;
            end else if (oc_cap_q && !req_q.write) begin
                xrdata_q <= ram_rdata;
            end
        end
    end

    // On-chip RAM, aliasing modulo its size
    assign ram_en = ram_en_q;
    assign ram_we = ram_en_q & req_q.write;
    assign ram_addr = eff_q[9:0];
    assign ram_wdata = req_q.wdata;

    // CPU handshake
    assign xreq_ready = (state_q == memory_port_pkg::ST_IDLE);
    assign xdone = (state_q == memory_port_pkg::ST_DONE);
    assign xrdata = xrdata_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic [7:0] acc_len_q; // Cycles since launch
    logic [4:0] strobe_len_q; // Cycles of a strobe on the pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_len_q <= '0;
            strobe_len_q <= '0;
        end else begin
            acc_len_q <= (state_q == memory_port_pkg::ST_IDLE) ? 8'h00 : acc_len_q + 8'h01;
            strobe_len_q <= (!pins_q.rd_n || !pins_q.wr_n) ? strobe_len_q + 5'h01 : 5'h00;
        end
    end
    wire logic [7:0] ale_total = mux_mode ? ({6'h0, ale_f} + 8'h01) + ({6'h0, ale_f} + 8'h01)
                                          : 8'h00;
    wire logic [7:0] exp_total = {6'h0, setup_f} + {4'h0, width_f} + 8'h01 + {6'h0, hold_f}
                                 + memory_port_pkg::EXTRA_CYCLES + ale_total;

    AST_ONE_STROBE: assert property (!(!pins_q.rd_n && !pins_q.wr_n))
        else $error("read and write strobes low together");
    AST_STROBE_DIR: assert property (!pins_q.rd_n |-> !req_q.write)
        else $error("read strobe during a write");
    AST_STROBE_WIDTH: assert property (
        (pins_q.rd_n && pins_q.wr_n && strobe_len_q != 5'h00)
        |-> strobe_len_q == {1'b0, width_f} + 5'h01)
        else $error("strobe width differs from field");
    AST_TOTAL: assert property ((xdone && offchip_q) |-> acc_len_q + 8'h01 == exp_total)
        else $error("off-chip access length wrong");
    AST_MIN_LEN: assert property ((xdone && offchip_q) |-> acc_len_q + 8'h01 >= 8'h05)
        else $error("off-chip access shorter than minimum");
    AST_RELEASE: assert property ($fell(pins_q.ctrl_oe) |-> xreq_ready)
        else $error("pins released late or early");
    AST_IDLE_FREE: assert property (xreq_ready |-> ##1 (!pins_q.ctrl_oe && !pins_q.data_oe))
        else $error("pins driven while idle");
    AST_READ_OFF: assert property (!pins_q.rd_n |-> !pins_q.data_oe)
        else $error("data driven during read strobe");
    AST_WDATA: assert property (!pins_q.wr_n |->
        (pins_q.data_oe && pins_q.data == req_q.wdata))
        else $error("write data not on pins");
    AST_NO_LATCH: assert property (!mux_mode |-> !pins_q.ale)
        else $error("latch strobe in separate mode");
    AST_ALE_ADDR: assert property (pins_q.ale |->
        (pins_q.data_oe && pins_q.data == eff_q[7:0]))
        else $error("low address missing in latch phase");
    AST_HI_UNDRIVEN: assert property ((pins_q.ctrl_oe && !req_q.wide
        && cfg_snap_q[memory_port_pkg::CFG_MODE_LSB +: 2] != memory_port_pkg::MODE_SPLIT_BANK)
        |-> !pins_q.hi_oe)
        else $error("upper pins driven in short form");
    AST_ONCHIP_MODE: assert property ($rose(ram_en) |->
        cfg_snap_q[memory_port_pkg::CFG_MODE_LSB +: 2] != memory_port_pkg::MODE_OFFCHIP)
        else $error("on-chip access in external-only mode");
    AST_TC_RESET: assert property ($rose(rstn) |->
        timing_q == memory_port_pkg::TIMING_RST)
        else $error("timing register not all ones");

    COV_MUX_READ: cover property (xdone && offchip_q && mux_mode && !req_q.write);
    COV_SEP_WRITE: cover property (xdone && offchip_q && !mux_mode && req_q.write);
    COV_ONCHIP: cover property (xdone && !offchip_q);
endmodule
`default_nettype wire

// ==== tb/sram_model.sv ====
// Off-chip byte memory with an address latch on the shared pins
`timescale 1ns/1ps
`default_nettype none
module sram_model (
    // Clock
    input wire logic clk,
    // Pins from the device
    input wire memory_port_pkg::pins_type pins,
    // Data pin level seen by the device
    output logic [7:0] data_i
);
    logic [7:0] mem [256];
    logic [7:0] lat_q;
    logic [7:0] last_q;
    logic [7:0] a;
    // Separate low address pins win, else the latched byte
    assign a = pins.lo_oe ? pins.lo : lat_q;
    // Transparent while strobe high, frozen after it falls
    always_latch begin
        if (pins.ale) lat_q <= pins.data;
    end
    // Store while the write strobe is low, since data may end with it; remember the wire
    always @(posedge clk) begin
        last_q <= data_i;
        if (!pins.wr_n) mem[a] <= pins.data;
    end
    // Wire level: device drive, memory on read, else a changing pattern
    assign data_i = pins.data_oe ? pins.data : (!pins.rd_n ? mem[a] : ~last_q);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the external memory interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, xreq_valid, xreq_ready, xdone;
    logic ram_en, ram_we, hi_seen, ram_seen;
    logic [9:0] avs_address, ram_addr, ram_seen_addr;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] xrdata, ram_wdata, ram_rdata, data_i, q, ram_wseen;
    memory_port_pkg::xreq_type xreq;
    memory_port_pkg::pins_type pins;
    int n, n_mismatch, checks, cyc;
    external_memory_interface external_memory_interface_inst (.clk(clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .xreq_valid(xreq_valid), .xreq(xreq),
        .xreq_ready(xreq_ready), .xdone(xdone), .xrdata(xrdata), .ram_en(ram_en),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
        .pins(pins), .data_i(data_i));
    sram_model sram_model_inst (.clk(clk), .pins(pins), .data_i(data_i));
    // Clock at 200 MHz
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    // Synchronous on-chip RAM returns the inverted address; watch pins
    always @(posedge clk) begin
        ram_rdata <= ~ram_addr[7:0];
        if (ram_en) ram_seen <= 1;
        if (ram_en) ram_seen_addr <= ram_addr;
        if (ram_we) ram_wseen <= ram_wdata;
        if (pins.hi_oe) hi_seen <= 1;
        if (!pins.rd_n && pins.data_oe) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, pins.data_oe, 1'b0);
        end
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One Avalon transfer held until waitrequest is seen low
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk);
    endtask
    // One external-move request; n counts cycles up to completion
    task automatic cpu(input logic w, input logic wd, input logic [15:0] dp, input logic [7:0] d);
        hi_seen = 0;
        ram_seen = 0;
        xreq_valid <= 1;
        xreq <= memory_port_pkg::xreq_type'({w, wd, dp[7:0], dp, d});
        do @(posedge clk); while (xreq_ready !== 1'b1);
        xreq_valid <= 0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (xdone !== 1'b1 && n < 100);
        @(posedge clk);
        q = xrdata;
        chk(pins.ctrl_oe, 0);
    endtask
    task automatic wrap_up();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {avs_read, avs_write, xreq_valid, avs_address, avs_writedata, xreq} = '0;
        n_mismatch = 0; checks = 0; cyc = 0; rstn = 0;
        repeat (16) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        bus(0, 10'h3dc, 0); chk(q, 8'hff);
        bus(0, 10'h31c, 0); chk(q, 8'h03);
        bus(0, 10'h004, 0); chk(q, 8'h00);
        bus(1, 10'h3dc, 8'h00);
        bus(1, 10'h31c, 8'h1c);
        cpu(1, 1, 16'h1234, 8'h5a); chk(n, 5);
        cpu(0, 1, 16'h0034, 0); chk(q, 8'h5a);
        chk(ram_seen, 0);
        bus(0, 10'h3e0, 0); chk(q, 8'h02);
        bus(1, 10'h31c, 8'h0d);
        cpu(0, 1, 16'h1234, 0); chk(q, 8'h5a);
        chk(n, 9);
        bus(1, 10'h3dc, 8'hff);
        cpu(1, 0, 16'h0077, 8'hc3); chk(n, 30);
        chk(hi_seen, 0);
        bus(1, 10'h31c, 8'h1c);
        cpu(0, 0, 16'h0077, 0); chk(q, 8'hc3);
        bus(1, 10'h3dc, 8'h00);
        bus(1, 10'h2a8, 8'h12);
        bus(1, 10'h31c, 8'h18);
        cpu(0, 0, 16'h0034, 0); chk(q, 8'h5a);
        chk(hi_seen, 1);
        bus(1, 10'h31c, 8'h14);
        cpu(0, 0, 16'h0034, 0); chk(hi_seen, 0);
        cpu(0, 1, 16'h1234, 0); chk(hi_seen, 1);
        chk(q, 8'h5a);
        cpu(0, 1, 16'h0200, 0); chk(ram_seen, 1);
        bus(1, 10'h31c, 8'h10);
        cpu(0, 1, 16'h1401, 0); chk(ram_seen_addr, 10'h001);
        chk(q, 8'hfe);
        cpu(1, 1, 16'h0405, 8'h3c); chk(ram_wseen, 8'h3c);
        chk(ram_seen_addr, 10'h005);
        wrap_up();
    end
endmodule
`default_nettype wire
